//--- alarm_pkg.sv
// Shared constants for the rectifier alarm and indicator encoder
package alarm_pkg;
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned PG_PULSE_US = 1000;
  localparam int unsigned PG_PULSE_CYC = (CLK_HZ / 1_000_000) * PG_PULSE_US;
  localparam int unsigned BLINK_MS = 250;
  localparam int unsigned BLINK_CYC = (CLK_HZ / 1000) * BLINK_MS;
  localparam int unsigned OTW_MARGIN_C = 5;

  // APB register map
  localparam logic [7:0] ADDR_COND = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_IRQ = 8'h08;
  localparam logic [7:0] ADDR_MASK = 8'h0C;
  localparam logic [7:0] ADDR_TEMP = 8'h10;
  localparam logic [7:0] ADDR_CTRL = 8'h14;

  // Condition register bit positions
  localparam int unsigned C_INFUSE = 0;
  localparam int unsigned C_OVLATCH = 1;
  localparam int unsigned C_INLIM = 2;
  localparam int unsigned C_OVCUR = 3;
  localparam int unsigned C_MINOR = 4;
  localparam int unsigned C_SVCREQ = 5;
  localparam int unsigned C_COMLOSS = 6;
  localparam int unsigned C_FAN1 = 7;
  localparam int unsigned C_FAN2 = 8;
  localparam int unsigned C_NOAC = 9;
  localparam int unsigned C_BOOST = 10;
  localparam int unsigned C_PGPRED = 11;
  localparam int unsigned COND_W = 12;
  localparam logic [COND_W-1:0] COND_RST = 12'h000;

  // Event bits
  localparam int unsigned E_FAULT = 0;
  localparam int unsigned E_PG = 1;
  localparam int unsigned E_OTW = 2;
  localparam int unsigned E_SHUT = 3;
  localparam int unsigned EV_W = 4;

  localparam logic [7:0] TEMP_RST = 8'h00;
  localparam logic [7:0] TSHUT_RST = 8'h69;

  typedef enum logic [2:0] {
    MODE_ANALOG = 3'b001,
    MODE_SMBUS = 3'b010,
    MODE_MULTIDROP = 3'b100
  } mode_e;
endpackage

//--- period_tick.sv
// Free-running divider producing a one-cycle tick each period
module period_tick #(
  parameter int unsigned PERIOD = 1000
) (
  input wire logic pclk,
  input wire logic presetn,
  output logic tick
);
  logic [$clog2(PERIOD+1)-1:0] count;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
      tick <= 1'b0;
    end else if (count == $bits(count)'(PERIOD - 1)) begin
      count <= '0;
      tick <= 1'b1;
    end else begin
      count <= count + 1'b1;
      tick <= 1'b0;
    end
  end
endmodule

//--- sticky_irq.sv
// Sticky event bits with write-one-to-clear and masked interrupt
module sticky_irq #(
  parameter int unsigned W = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] event_in,
  input wire logic clr_en,
  input wire logic [W-1:0] clr_bits,
  input wire logic mask_we,
  input wire logic [W-1:0] mask_wdata,
  output logic [W-1:0] flags,
  output logic [W-1:0] mask,
  output logic irq
);
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      // Set wins over a simultaneous clear
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          flags[i] <= 1'b0;
        end else if (event_in[i]) begin
          flags[i] <= 1'b1;
        end else if (clr_en && clr_bits[i]) begin
          flags[i] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask <= '0;
    end else if (mask_we) begin
      mask <= mask_wdata;
    end
  end

  assign irq = |(flags & mask);
endmodule

//--- rectifier_alarm_status_encoder.sv
// Rectifier condition encoder: indicators, alarm pins, APB registers
//
// How it works
// RL1: Pre-alarm lights service, pulls over-temp low
// RL2: Over-temp warning asserts five degrees before shutdown
// RL3: Blown fuse: fault lit, fault/pg low
// RL4: Latched overvoltage: output off, fault/pg low
// RL5: Input out of limits blinks input LED
// RL6: Overcurrent blinks output, pulses power-good
// RL7: Non-shutdown fault: fault LED, fault low
// RL8: Service request blinks service in smbus mode
// RL9: Communication loss blinks fault in multidrop
// RL10: One fan tolerated, two force shutdown
// RL11: Output enabled only with on/off grounded; multidrop mode ignores on/off
// RL12: Power-good low when output loss predicted
// RL13: Fault output high unless a fault exists
// RL14: Protocol pin selects smbus or multidrop mode
// RL15: Identity levels give four low address bits
// RL16: Interlock pin gates the main output
// RL17: Thermal shutdown: all alarms low
// RL18: Shutdowns outrank warnings; blink from prescaler
//
// Decided for this implementation: the placing of the registers and register access over APB.
module rectifier_alarm_status_encoder #(
  parameter int unsigned PG_PULSE_CYCLES = alarm_pkg::PG_PULSE_CYC,
  parameter int unsigned BLINK_CYCLES = alarm_pkg::BLINK_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic on_off_grounded,
  input wire logic interlock_mated,
  input wire logic protocol_open,
  input wire logic protocol_resistor,
  input wire logic [3:0] unit_ident_level,
  input wire logic [3:0] rack_ident_level,
  output logic [3:0] low_address_bits,
  output logic main_output_en,
  output alarm_pkg::mode_e mode,
  output logic led_input,
  output logic led_output,
  output logic led_service,
  output logic led_fault,
  output logic fault_n_oe_n,
  output logic power_good_warn_n_oe_n,
  output logic overtemp_warn_n_oe_n,
  output logic module_seated_oe_n,
  output logic fault_n,
  output logic power_good_warn_n,
  output logic overtemp_warn_n,
  output logic module_seated
);
  import alarm_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // Register file
  logic [COND_W-1:0] cond;
  logic [7:0] temp_c;
  logic [7:0] tshut_c;
  logic [EV_W-1:0] flags;
  logic [EV_W-1:0] mask;
  logic [EV_W-1:0] events;
  logic wr;
  logic mapped;
  logic [2:0] prev_alarm;
  logic prev_shut;

  function automatic logic addr_hit(input logic [7:0] a,
                                    input logic [7:0] off);
    return a == off;
  endfunction

  assign wr = psel && penable && pwrite;
  assign pready = 1'b1;
  assign mapped = addr_hit(paddr, ADDR_COND) || addr_hit(paddr, ADDR_STATUS)
               || addr_hit(paddr, ADDR_IRQ) || addr_hit(paddr, ADDR_MASK)
               || addr_hit(paddr, ADDR_TEMP) || addr_hit(paddr, ADDR_CTRL);
  assign pslverr = psel && penable && !mapped;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cond <= COND_RST;
    end else if (wr && addr_hit(paddr, ADDR_COND)) begin
      cond <= pwdata[COND_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      temp_c <= TEMP_RST;
      tshut_c <= TSHUT_RST;
    end else if (wr && addr_hit(paddr, ADDR_TEMP)) begin
      temp_c <= pwdata[7:0];
      tshut_c <= pwdata[15:8];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Mode and address straps
  mode_e next_mode;
  always_comb begin
    if (protocol_resistor) begin
      next_mode = MODE_MULTIDROP; // [RL14]
    end else if (protocol_open) begin
      next_mode = MODE_SMBUS; // [RL14]
    end else begin
      next_mode = MODE_ANALOG;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode <= MODE_SMBUS;
      low_address_bits <= 4'h0;
    end else begin
      mode <= next_mode;
      low_address_bits <= unit_ident_level ^ rack_ident_level; // [RL15]
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Blink and power-good pulse timing
  logic blink_tick;
  logic pg_tick;
  logic blink;
  logic pg_pulse;

  period_tick #(.PERIOD(BLINK_CYCLES)) u_blink (
    .pclk(pclk),
    .presetn(presetn),
    .tick(blink_tick)
  );

  period_tick #(.PERIOD(PG_PULSE_CYCLES)) u_pg (
    .pclk(pclk),
    .presetn(presetn),
    .tick(pg_tick)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blink <= 1'b0;
    end else if (blink_tick) begin
      blink <= !blink; // [RL18]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pg_pulse <= 1'b0;
    end else if (!cond[C_OVCUR]) begin
      pg_pulse <= 1'b0;
    end else if (pg_tick) begin
      pg_pulse <= !pg_pulse; // [RL6]
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Condition priority encoding
  logic thermal_shut;
  logic thermal_warn;
  logic [8:0] temp_margin;
  logic li, lo, ls, lf, fa, pg, ot;
  logic out_allowed;
  logic run_ok;
  logic hard_shut;

  assign temp_margin = {1'b0, temp_c} + 9'(OTW_MARGIN_C);
  assign thermal_shut = temp_c >= tshut_c;
  assign thermal_warn = temp_margin >= {1'b0, tshut_c}; // [RL2]
  assign hard_shut = thermal_shut || cond[C_FAN2];

  always_comb begin
    li = 1'b1;
    lo = 1'b1;
    ls = 1'b0;
    lf = 1'b0;
    fa = 1'b1;
    pg = 1'b1;
    ot = 1'b1;
    run_ok = 1'b1;
    // Shutdowns first, then warnings
    if (thermal_shut) begin
      lo = 1'b0; // [RL17]
      run_ok = 1'b0;
      ls = 1'b1;
      lf = 1'b1;
      fa = 1'b0;
      pg = 1'b0;
      ot = 1'b0;
    end else if (cond[C_FAN2]) begin
      lo = 1'b0; // [RL10]
      run_ok = 1'b0;
      lf = 1'b1;
      fa = 1'b0;
      pg = 1'b0;
    end else if (cond[C_INFUSE] || cond[C_BOOST]) begin
      lo = 1'b0; // [RL3]
      run_ok = 1'b0;
      lf = 1'b1;
      fa = 1'b0;
      pg = 1'b0;
    end else if (cond[C_OVLATCH]) begin
      lo = 1'b0; // [RL4]
      run_ok = 1'b0;
      lf = 1'b1;
      fa = 1'b0;
      pg = 1'b0;
    end else if (cond[C_NOAC]) begin
      run_ok = 1'b0;
      li = 1'b0;
      lo = 1'b0;
      pg = 1'b0;
    end else if (cond[C_INLIM]) begin
      li = blink; // [RL5]
      run_ok = 1'b0;
      lo = 1'b0;
      pg = 1'b0;
    end else if (thermal_warn) begin
      ls = 1'b1; // [RL1]
      ot = 1'b0; // [RL2]
    end else if (cond[C_OVCUR]) begin
      lo = blink; // [RL6]
      pg = !pg_pulse; // [RL6]
    end else if (cond[C_MINOR]) begin
      lf = 1'b1; // [RL7]
      fa = 1'b0; // [RL13]
    end else if (mode == MODE_SMBUS && cond[C_SVCREQ]) begin
      ls = blink; // [RL8]
    end else if (mode == MODE_MULTIDROP && cond[C_COMLOSS]) begin
      lf = blink; // [RL9]
    end
    // Single fan failure alone changes nothing here [RL10]
    if (!out_allowed && fa) begin
      lo = 1'b0;
      pg = 1'b0;
    end
    if (cond[C_PGPRED]) begin
      pg = 1'b0; // [RL12]
    end
  end

  // Standby unless on/off grounded (analog/smbus) and interlock mated
  assign out_allowed = interlock_mated // [RL16]
      && (on_off_grounded || next_mode == MODE_MULTIDROP); // [RL11]

  ////////////////////////////////////////////////////////////////////
  // Registered outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      led_input <= 1'b0;
      led_output <= 1'b0;
      led_service <= 1'b0;
      led_fault <= 1'b0;
      fault_n <= 1'b1;
      power_good_warn_n <= 1'b1;
      overtemp_warn_n <= 1'b1;
      module_seated <= 1'b0;
    end else begin
      led_input <= li;
      led_output <= lo;
      led_service <= ls;
      led_fault <= lf;
      fault_n <= fa; // [RL13]
      power_good_warn_n <= pg;
      overtemp_warn_n <= ot;
      module_seated <= 1'b0;
    end
  end

  // Output runs unless in standby or stopped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_output_en <= 1'b0;
    end else begin
      main_output_en <= out_allowed && run_ok; // [RL16]
    end
  end

  // Open drain: enable low pulls the wire low
  assign fault_n_oe_n = fault_n;
  assign power_good_warn_n_oe_n = power_good_warn_n;
  assign overtemp_warn_n_oe_n = overtemp_warn_n;
  assign module_seated_oe_n = module_seated;

  ////////////////////////////////////////////////////////////////////
  // Events and interrupt
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_alarm <= 3'b111;
      prev_shut <= 1'b0;
    end else begin
      prev_alarm <= {overtemp_warn_n, power_good_warn_n, fault_n};
      prev_shut <= hard_shut;
    end
  end

  assign events[E_FAULT] = prev_alarm[0] && !fault_n;
  assign events[E_PG] = prev_alarm[1] && !power_good_warn_n;
  assign events[E_OTW] = prev_alarm[2] && !overtemp_warn_n;
  assign events[E_SHUT] = !prev_shut && hard_shut;

  sticky_irq #(.W(EV_W)) u_irq (
    .pclk(pclk),
    .presetn(presetn),
    .event_in(events),
    .clr_en(wr && addr_hit(paddr, ADDR_IRQ)),
    .clr_bits(pwdata[EV_W-1:0]),
    .mask_we(wr && addr_hit(paddr, ADDR_MASK)),
    .mask_wdata(pwdata[EV_W-1:0]),
    .flags(flags),
    .mask(mask),
    .irq(irq)
  );

  ////////////////////////////////////////////////////////////////////
  // Read data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= 32'h0000_0000;
      case (paddr)
        ADDR_COND: prdata <= {20'h0_0000, cond};
        ADDR_STATUS: prdata <= {16'h0000, mode, low_address_bits,
                               main_output_en, module_seated,
                               overtemp_warn_n, power_good_warn_n, fault_n,
                               led_fault, led_service, led_output, led_input};
        ADDR_IRQ: prdata <= {28'h000_0000, flags};
        ADDR_MASK: prdata <= {28'h000_0000, mask};
        ADDR_TEMP: prdata <= {16'h0000, tshut_c, temp_c};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule

//--- alarm_checker_sva.sv
// Port-level checker for the rectifier alarm encoder
module alarm_checker
  import alarm_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pslverr,
  input wire logic on_off_grounded,
  input wire logic interlock_mated,
  input wire logic protocol_open,
  input wire logic protocol_resistor,
  input wire logic [3:0] unit_ident_level,
  input wire logic [3:0] rack_ident_level,
  input wire logic [3:0] low_address_bits,
  input wire logic main_output_en,
  input wire alarm_pkg::mode_e mode,
  input wire logic led_input,
  input wire logic led_output,
  input wire logic led_service,
  input wire logic led_fault,
  input wire logic fault_n_oe_n,
  input wire logic fault_n,
  input wire logic overtemp_warn_n,
  input wire logic module_seated
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_warn;
    !overtemp_warn_n && fault_n;
  endsequence
  sequence s_lit;
    led_service && led_input && led_output;
  endsequence
  sequence s_shut;
    !overtemp_warn_n && !fault_n;
  endsequence
  AST_PREALARM: assert property (s_warn |-> s_lit)
    else $error("pre-alarm indicators wrong");
  AST_SHUTDOWN: assert property (
    s_shut |-> !led_output && led_service)
    else $error("thermal shutdown indicators wrong");
  AST_FAULT_LED: assert property (!fault_n |-> led_fault)
    else $error("fault pin low without fault lamp");
  AST_FAULT_PIN: assert property (fault_n_oe_n == fault_n)
    else $error("fault pin drive differs from level");
  AST_ONOFF: assert property (
    !on_off_grounded && !protocol_resistor |=> !main_output_en)
    else $error("output on while on/off open");
  AST_INTERLOCK: assert property (
    !interlock_mated |=> !main_output_en)
    else $error("output on while interlock open");
  AST_MODE_MD: assert property (
    protocol_resistor |=> mode == MODE_MULTIDROP)
    else $error("resistor did not pick multidrop");
  AST_MODE_SM: assert property (
    protocol_open && !protocol_resistor |=> mode == MODE_SMBUS)
    else $error("open pin did not pick smbus");
  AST_ADDR: assert property (
    1'b1 |=> low_address_bits ==
      ($past(unit_ident_level) ^ $past(rack_ident_level)))
    else $error("address bits not from ident levels");
  AST_ERR_PHASE: assert property (pslverr |-> psel && penable)
    else $error("error outside access phase");
  AST_SEATED: assert property (!module_seated)
    else $error("presence pin not low");
endmodule
bind rectifier_alarm_status_encoder alarm_checker chk_u (.pclk, .presetn,
  .psel, .penable, .pslverr, .on_off_grounded, .interlock_mated,
  .protocol_open, .protocol_resistor, .unit_ident_level, .rack_ident_level,
  .low_address_bits, .main_output_en, .mode, .led_input, .led_output,
  .led_service, .led_fault, .fault_n_oe_n, .fault_n, .overtemp_warn_n,
  .module_seated);

//--- shelf_host_model.sv
// Shelf controller: alarm pull-ups and control pin drive
module shelf_host_model (
  input wire logic pclk,
  input wire logic [3:0] alarm_oe_n,
  input wire logic [11:0] req,
  output logic [3:0] wires,
  output logic [11:0] ctl
);
  timeunit 1ns;
  timeprecision 1ns;
  // Released lines float to the pull-up, driven ones sit low
  assign wires = alarm_oe_n;
  // Control pins change just after the edge
  always_ff @(posedge pclk) ctl <= req;
endmodule

//--- rectifier_alarm_status_encoder_test.sv
// Self-checking bench for the rectifier alarm encoder
`define CHK(g, x) begin check_count++; if ((g) !== (x)) begin miscompares++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, x); end end
module rectifier_alarm_status_encoder_test;
  timeunit 1ns;
  timeprecision 1ns;
  import alarm_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic e, on_off_grounded, interlock_mated, protocol_open, protocol_resistor;
  logic [3:0] unit_ident_level, rack_ident_level, low_address_bits, w;
  logic main_output_en, led_input, led_output, led_service, led_fault;
  logic fault_n_oe_n, power_good_warn_n_oe_n, overtemp_warn_n_oe_n;
  logic module_seated_oe_n, fault_n, power_good_warn_n, overtemp_warn_n;
  logic module_seated, r_on, r_il, r_po, r_pr;
  logic [3:0] r_unit, r_rack;
  logic [6:0] vec;
  mode_e mode;
  int miscompares, check_count;
  int conds[$] = '{0, 1, 2, 4, 8, 16, 32, 64, 128, 256, 512, 1024, 2048, 9};
  int temps[$] = '{99, 100, 105};
  assign vec = {w[2:0], led_fault, led_service, led_output, led_input};
  rectifier_alarm_status_encoder #(.PG_PULSE_CYCLES(8), .BLINK_CYCLES(4))
  dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .irq, .on_off_grounded, .interlock_mated,
    .protocol_open, .protocol_resistor, .unit_ident_level,
    .rack_ident_level, .low_address_bits, .main_output_en, .mode,
    .led_input, .led_output, .led_service, .led_fault, .fault_n_oe_n,
    .power_good_warn_n_oe_n, .overtemp_warn_n_oe_n, .module_seated_oe_n,
    .fault_n, .power_good_warn_n, .overtemp_warn_n, .module_seated);
  shelf_host_model host_u (.pclk, .wires(w), .req({r_on, r_il, r_po, r_pr,
    r_unit, r_rack}), .alarm_oe_n({module_seated_oe_n, overtemp_warn_n_oe_n,
    power_good_warn_n_oe_n, fault_n_oe_n}), .ctl({on_off_grounded,
    interlock_mated, protocol_open, protocol_resistor, unit_ident_level,
    rack_ident_level}));
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic cyc(int k);
    repeat (k) @(posedge pclk);
    @(negedge pclk);
  endtask
  task automatic apb(bit wr, logic [7:0] a, logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      miscompares++;
      tally_and_finish();
    end
  endtask
  // Result is {blinking bits, bits cared for, expected levels}
  function automatic logic [20:0] model(int c, int t, bit md);
    int s = TSHUT_RST;
    if (t >= s) return {7'h00, 7'h7F, 7'h0D};
    if (c & 'h503) return {7'h00, 7'h7F, 7'h49};
    if (c[9]) return {7'h00, 7'h7F, 7'h50};
    if (c[2]) return {7'h01, 7'h7E, 7'h50};
    if (t + 5 >= s) return {7'h00, 7'h7F, 7'h37};
    if (c[3]) return {7'h22, 7'h5D, 7'h51};
    if (c[4]) return {7'h00, 7'h7F, 7'h6B};
    if (c[5] && !md) return {7'h04, 7'h7B, 7'h73};
    if (c[6] && md) return {7'h08, 7'h77, 7'h73};
    if (c[11]) return {7'h00, 7'h20, 7'h00};
    if (c[7]) return {7'h00, 7'h02, 7'h02};
    return {7'h00, 7'h7F, 7'h73};
  endfunction
  task automatic scen(int c, int t, bit md);
    logic [20:0] m;
    logic [6:0] hi, lo;
    m = model(c, t, md);
    apb(1'b1, ADDR_TEMP, {16'h0000, TSHUT_RST, 8'(t)});
    apb(1'b1, ADDR_COND, 32'(c));
    cyc(3);
    `CHK(vec & m[13:7], m[6:0])
    `CHK(main_output_en, 1'(!(c & 'h707) && t < TSHUT_RST))
    hi = '0;
    lo = '0;
    repeat (24) begin
      @(negedge pclk);
      hi |= vec;
      lo |= ~vec;
    end
    `CHK(hi & lo & m[20:14], m[20:14])
    apb(1'b0, ADDR_STATUS, 32'h0000_0000);
    `CHK(q[6:0] & m[13:7], m[6:0])
    $display("test cond=%h temp=%0d done", c, t);
  endtask
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {r_on, r_il, r_po, r_pr, r_unit, r_rack} = 12'hE00;
    miscompares = 0;
    check_count = 0;
    void'($urandom(97));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ADDR_TEMP, 32'h0000_0000);
    `CHK(q, {16'h0000, TSHUT_RST, TEMP_RST})
    apb(1'b0, 8'h40, 32'h0000_0000);
    `CHK({e, q}, 33'h1_0000_0000)
    foreach (conds[i]) scen(conds[i], 0, 1'b0);
    foreach (temps[i]) scen(0, temps[i], 1'b0);
    @(posedge pclk) r_pr <= 1'b1;
    cyc(3);
    `CHK(mode, MODE_MULTIDROP)
    scen('h40, 0, 1'b1);
    scen('h20, 0, 1'b1);
    @(posedge pclk) {r_po, r_pr} <= 2'b00;
    cyc(3);
    `CHK(mode, MODE_ANALOG)
    for (int i = 0; i < 3; i++) begin
      @(posedge pclk) {r_on, r_il} <= 2'(i + 1);
      cyc(3);
      `CHK(main_output_en, 1'(i == 2))
    end
    repeat (4) begin
      @(posedge pclk) {r_unit, r_rack} <= 8'($urandom);
      cyc(3);
      `CHK(low_address_bits, r_unit ^ r_rack)
    end
    $display("test pins done");
    apb(1'b1, ADDR_COND, 32'h0000_0000);
    apb(1'b1, ADDR_IRQ, 32'h0000_000F);
    apb(1'b1, ADDR_MASK, 32'h0000_0001);
    apb(1'b0, ADDR_IRQ, 32'h0000_0000);
    `CHK(q, 32'h0000_0000)
    apb(1'b1, ADDR_COND, 32'h0000_0001);
    cyc(3);
    `CHK(irq, 1'b1)
    apb(1'b0, ADDR_IRQ, 32'h0000_0000);
    `CHK(q[1:0], 2'b11)
    apb(1'b1, ADDR_MASK, 32'h0000_0000);
    cyc(1);
    `CHK(irq, 1'b0)
    apb(1'b1, ADDR_IRQ, 32'h0000_000F);
    apb(1'b0, ADDR_IRQ, 32'h0000_0000);
    `CHK(q, 32'h0000_0000)
    $display("test irq done");
    tally_and_finish();
  end
endmodule
